// File: logic/shcc_pkg.sv
// shcc_pkg: constants and types for the serial peripheral host/client core
package shcc_pkg;
	localparam int SHCC_DATA_W = 8;
	localparam logic [2:0] SHCC_BIT_LAST = 3'h7;
	localparam logic [6:0] SHCC_CLOCK_PRESCALER_RESET = 7'h00;
	localparam logic [7:0] SHCC_BYTE_RESET = 8'h00;
	localparam logic [6:0] SHCC_DIV_ONE = 7'h01;
	// half-period counts for prescaler codes 0..3 (divide by 4, 16, 64, 128)
	localparam logic [6:0] SHCC_HALF_DIV4 = 7'h02;
	localparam logic [6:0] SHCC_HALF_DIV16 = 7'h08;
	localparam logic [6:0] SHCC_HALF_DIV64 = 7'h20;
	localparam logic [6:0] SHCC_HALF_DIV128 = 7'h40;
	typedef enum logic [1:0] {SHCC_IDLE, SHCC_LOW, SHCC_HIGH} shcc_phase_e;
endpackage : shcc_pkg

// File: logic/shcc_core.sv
// shcc_core: byte-wide serial peripheral core, host and client roles
`timescale 1ns/10ps
`default_nettype none
module shcc_core (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic host_set,
	input wire logic [1:0] clock_prescaler,
	input wire logic clock_doubler,
	input wire logic bit_order,
	input wire logic buffer_enable,
	input wire logic wait_for_receive,
	input wire logic select_disable,
	input wire logic transfer_irq_enable,
	input wire logic transfer_complete_enable,
	input wire logic global_irq_enable,
	input wire logic data_wr,
	input wire logic [shcc_pkg::SHCC_DATA_W-1:0] data_wdata,
	input wire logic data_rd,
	output logic [shcc_pkg::SHCC_DATA_W-1:0] data_rdata,
	input wire logic flag_clear_transfer,
	input wire logic flag_clear_collision,
	input wire logic flag_clear_complete,
	output logic host_mode,
	output logic transfer_flag,
	output logic write_collision_flag,
	output logic data_empty_flag,
	output logic transfer_complete_flag,
	output logic rx_valid,
	output logic irq,
	input wire logic sck_dir_out,
	input wire logic mosi_dir_out,
	input wire logic miso_dir_out,
	input wire logic ss_dir_out,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_in,
	output logic ss_out,
	output logic ss_oe
);
	import shcc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic host;
		logic [7:0] shifter;
		logic [2:0] bitcnt;
		shcc_phase_e phase;
		logic [6:0] divcnt;
		logic in_bit;
		logic [7:0] txbuf;
		logic txbuf_full;
		logic [7:0] rxq0;
		logic [7:0] rxq1;
		logic [1:0] rxcnt;
		logic tflag;
		logic wcol;
		logic dre;
		logic tcomp;
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		logic host_q;
	} shcc_state_s;

	shcc_state_s st;
	shcc_state_s next_st;

	logic [6:0] half;
	logic lsb_first;
	logic busy;
	logic done;
	logic [7:0] rx_byte;
	logic client_sel;
	logic rise;
	logic fall;
	logic out_bit;

	// ----------------------------------------------------------------
	// rate select
	// ----------------------------------------------------------------
	always_comb begin
		case (clock_prescaler)
			2'h0: half = SHCC_HALF_DIV4;
			2'h1: half = SHCC_HALF_DIV16;
			2'h2: half = SHCC_HALF_DIV64;
			default: half = SHCC_HALF_DIV128;
		endcase
		// doubler halves the period; 128 with doubler stays at 128 (seven rates)
		if (clock_doubler && half != SHCC_HALF_DIV128) begin
			half = half >> 1;
		end
		if (half == 7'h00) begin
			half = SHCC_DIV_ONE;
		end
	end

	assign lsb_first = bit_order;
	assign busy = (st.phase != SHCC_IDLE);
	assign client_sel = !st.host && !ss_in;
	// only the synchronised second and third stages feed edge detection
	assign rise = st.sck_s2 && !st.sck_s3;
	assign fall = !st.sck_s2 && st.sck_s3;
	assign out_bit = lsb_first ? st.shifter[0] : st.shifter[7];
	assign rx_byte = lsb_first ? {st.in_bit, st.shifter[7:1]} : {st.shifter[6:0], st.in_bit};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		done = 1'b0;
		next_st.sck_s1 = sck_in;
		next_st.sck_s2 = st.sck_s1;
		next_st.sck_s3 = st.sck_s2;
		next_st.host_q = host_set;
		if (host_set && !st.host_q) begin
			next_st.host = 1'b1;
		end
		if (flag_clear_transfer) next_st.tflag = 1'b0;
		if (flag_clear_collision) next_st.wcol = 1'b0;
		if (flag_clear_complete) next_st.tcomp = 1'b0;
		if (data_rd && buffer_enable && st.rxcnt != 2'h0) begin
			next_st.rxq0 = st.rxq1;
			next_st.rxcnt = st.rxcnt - 2'h1;
		end
		if (!enable) begin
			next_st.phase = SHCC_IDLE;
			next_st.bitcnt = 3'h0;
		end else if (st.host) begin
			// select low as input while multi-host allowed: yield the bus
			if (!select_disable && !ss_dir_out && !ss_in) begin
				next_st.host = 1'b0;
				next_st.phase = SHCC_IDLE;
				next_st.tflag = 1'b1;
			end else begin
				case (st.phase)
					SHCC_IDLE: begin
						if (buffer_enable && st.txbuf_full) begin
							next_st.shifter = st.txbuf;
							next_st.txbuf_full = 1'b0;
							next_st.dre = 1'b1;
							next_st.phase = SHCC_LOW;
							next_st.divcnt = 7'h00;
						end
					end
					SHCC_LOW: begin
						if (st.divcnt + 7'h01 >= half) begin
							next_st.divcnt = 7'h00;
							next_st.in_bit = miso_in;
							next_st.phase = SHCC_HIGH;
						end else begin
							next_st.divcnt = st.divcnt + 7'h01;
						end
					end
					SHCC_HIGH: begin
						if (st.divcnt + 7'h01 >= half) begin
							next_st.divcnt = 7'h00;
							next_st.shifter = rx_byte;
							next_st.bitcnt = st.bitcnt + 3'h1;
							if (st.bitcnt == SHCC_BIT_LAST) begin
								done = 1'b1;
								next_st.phase = SHCC_IDLE;
							end else begin
								next_st.phase = SHCC_LOW;
							end
						end else begin
							next_st.divcnt = st.divcnt + 7'h01;
						end
					end
					default: next_st.phase = SHCC_IDLE;
				endcase
			end
		end else begin
			// client: halted while deselected, partial byte lost
			if (ss_in) begin
				next_st.bitcnt = 3'h0;
				next_st.phase = SHCC_IDLE;
			end else begin
				next_st.phase = SHCC_LOW;
				if (rise) begin
					next_st.in_bit = mosi_in;
				end
				if (fall) begin
					next_st.shifter = rx_byte;
					next_st.bitcnt = st.bitcnt + 3'h1;
					if (st.bitcnt == SHCC_BIT_LAST) begin
						done = 1'b1;
						if (buffer_enable && st.txbuf_full) begin
							next_st.shifter = st.txbuf;
							next_st.txbuf_full = 1'b0;
							next_st.dre = 1'b1;
						end
					end
				end
			end
		end
		if (done) begin
			if (buffer_enable) begin
				// third byte overwrites the newest entry when software lags
				if (next_st.rxcnt == 2'h0) begin
					next_st.rxq0 = rx_byte;
					next_st.rxcnt = 2'h1;
				end else begin
					next_st.rxq1 = rx_byte;
					next_st.rxcnt = 2'h2;
				end
				if (!(st.host && st.txbuf_full) && !(!st.host && st.txbuf_full)) begin
					next_st.tcomp = 1'b1;
				end
			end else begin
				next_st.rxq0 = rx_byte;
				next_st.tflag = 1'b1;
			end
		end
		if (data_wr && enable) begin
			if (buffer_enable) begin
				if (st.host && !busy && !st.txbuf_full) begin
					next_st.shifter = data_wdata;
					next_st.phase = SHCC_LOW;
					next_st.divcnt = 7'h00;
					next_st.bitcnt = 3'h0;
				end else if (st.dre) begin
					next_st.txbuf = data_wdata;
					next_st.txbuf_full = 1'b1;
					next_st.dre = 1'b0;
				end
			end else if (st.host) begin
				if (busy) begin
					next_st.shifter = data_wdata;
					next_st.wcol = 1'b1;
				end else begin
					next_st.shifter = data_wdata;
					next_st.phase = SHCC_LOW;
					next_st.divcnt = 7'h00;
					next_st.bitcnt = 3'h0;
				end
			end else if (client_sel && st.bitcnt != 3'h0) begin
				next_st.wcol = 1'b1;
			end else begin
				next_st.shifter = data_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{host: 1'b0, shifter: SHCC_BYTE_RESET, bitcnt: 3'h0, phase: SHCC_IDLE,
				divcnt: SHCC_CLOCK_PRESCALER_RESET, in_bit: 1'b0, txbuf: SHCC_BYTE_RESET,
				txbuf_full: 1'b0, rxq0: SHCC_BYTE_RESET, rxq1: SHCC_BYTE_RESET,
				rxcnt: 2'h0, tflag: 1'b0, wcol: 1'b0, dre: 1'b1, tcomp: 1'b0,
				sck_s1: 1'b0, sck_s2: 1'b0, sck_s3: 1'b0, host_q: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs and pins
	// ----------------------------------------------------------------
	assign data_rdata = st.rxq0;
	assign host_mode = st.host;
	assign transfer_flag = st.tflag;
	assign write_collision_flag = st.wcol;
	assign data_empty_flag = st.dre;
	assign transfer_complete_flag = st.tcomp;
	assign rx_valid = (st.rxcnt != 2'h0);
	assign irq = global_irq_enable && ((transfer_irq_enable && st.tflag)
		|| (transfer_complete_enable && st.tcomp));

	assign sck_out = (st.phase == SHCC_HIGH);
	assign mosi_out = out_bit;
	assign miso_out = out_bit;
	// select stays low through the byte; user output direction applies
	assign ss_out = !(st.host && busy);
	// role inputs forced to input while enabled
	assign sck_oe = enable ? (st.host && sck_dir_out) : sck_dir_out;
	assign mosi_oe = enable ? (st.host && mosi_dir_out) : mosi_dir_out;
	assign ss_oe = enable ? (st.host && ss_dir_out) : ss_dir_out;
	assign miso_oe = enable ? (!st.host && miso_dir_out && !ss_in) : miso_dir_out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_collision_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && st.host && !buffer_enable && busy && data_wr && !flag_clear_collision)
		|=> write_collision_flag) else $error("write collision not flagged");
	a_miso_tristate: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && ss_in) |-> !miso_oe || st.host) else $error("miso driven while deselected");
	a_yield_host: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && st.host && !select_disable && !ss_dir_out && !ss_in)
		|=> !host_mode && transfer_flag) else $error("host did not yield");
	a_normal_done: assert property (@(posedge ref_clk) disable iff (!resetn)
		(done && !buffer_enable) |=> transfer_flag) else $error("transfer flag missing");
	a_client_halt: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && !st.host && ss_in) |=> st.bitcnt == 3'h0) else $error("partial byte kept");
	a_dre_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && buffer_enable && data_wr && st.dre && (busy || st.txbuf_full))
		|=> !data_empty_flag) else $error("empty flag not cleared");
	a_start_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && st.host && !busy && data_wr && !buffer_enable && !(!select_disable
		&& !ss_dir_out && !ss_in)) |=> st.phase == SHCC_LOW) else $error("write did not start");
	a_inputs_forced: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable && !st.host) |-> !sck_oe && !mosi_oe && !ss_oe) else $error("input driven");
endmodule : shcc_core
`default_nettype wire

// File: test/shcc_client_model.sv
// client partner model for the serial host/client core
`timescale 1ns/10ps
`default_nettype none
module shcc_client_model (
	input wire logic sck,
	input wire logic select_n,
	input wire logic mosi,
	input wire logic lsb_first,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [7:0] sr = 8'h00;
	logic [7:0] nx = 8'h00;
	logic [3:0] cnt = 4'h0;
	logic held = 1'h0;
	// released line has no pull: show the inverse of the last bit
	assign miso = select_n ? ~held : (lsb_first ? sr[0] : sr[7]);
	always @(negedge select_n) begin
		sr = tx_byte;
		cnt = 4'h0;
	end
	always @(posedge select_n) held = lsb_first ? sr[0] : sr[7];
	// sample on rising, shift on falling, so the host never races us
	always @(posedge sck) if (!select_n) begin
		nx = lsb_first ? {mosi, sr[7:1]} : {sr[6:0], mosi};
		cnt = cnt + 4'h1;
		if (cnt == 4'h8) rx_byte = nx;
	end
	always @(negedge sck) if (!select_n) begin
		sr = (cnt == 4'h8) ? tx_byte : nx;
		if (cnt == 4'h8) cnt = 4'h0;
	end
endmodule // shcc_client_model
`default_nettype wire

// File: test/test_shcc_core.sv
// self-checking bench for the serial host/client core
`timescale 1ns/10ps
`default_nettype none
module test_shcc_core;
	import shcc_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic ref_clk = 1'h0, resetn = 1'h0, enable = 1'h0, host_set = 1'h0;
	logic [1:0] clock_prescaler = 2'h0;
	logic clock_doubler = 1'h0, bit_order = 1'h0, buffer_enable = 1'h0;
	logic wait_for_receive = 1'h0, select_disable = 1'h0, transfer_irq_enable = 1'h0;
	logic transfer_complete_enable = 1'h0, global_irq_enable = 1'h0, data_wr = 1'h0;
	logic [SHCC_DATA_W-1:0] data_wdata = 8'h00;
	logic [SHCC_DATA_W-1:0] data_rdata;
	logic data_rd = 1'h0, flag_clear_transfer = 1'h0, flag_clear_collision = 1'h0;
	logic flag_clear_complete = 1'h0, sck_dir_out = 1'h0, mosi_dir_out = 1'h0;
	logic miso_dir_out = 1'h0, ss_dir_out = 1'h0, tb_ss = 1'h1;
	logic tb_sck = 1'h0, tb_mosi = 1'h0;
	logic [7:0] got_m = 8'h00;
	logic host_mode, transfer_flag, write_collision_flag, data_empty_flag;
	logic transfer_complete_flag, rx_valid, irq, m_miso;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
	wire logic sck_in, mosi_in, miso_in, ss_in;
	logic [7:0] reply = 8'h00;
	logic [7:0] got;
	logic [7:0] half [4] = '{8'h02, 8'h08, 8'h20, 8'h40};
	// doubled rates; the slowest code is capped, which leaves seven in all
	logic [7:0] half2 [4] = '{8'h01, 8'h04, 8'h10, 8'h40};
	logic [31:0] seed = 32'h49FC;
	logic [7:0] exp_q [$];
	int errors = 0, checks = 0;
	assign ss_in = ss_oe ? ss_out : tb_ss;
	assign sck_in = sck_oe ? sck_out : tb_sck;
	assign mosi_in = mosi_oe ? mosi_out : tb_mosi;
	assign miso_in = miso_oe ? miso_out : m_miso;
	shcc_core i_dut (.*);
	shcc_client_model i_client (.sck(sck_in), .select_n(ss_in), .mosi(mosi_in),
		.lsb_first(bit_order), .tx_byte(reply), .miso(m_miso), .rx_byte(got));
	always #4 ref_clk = ~ref_clk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	task automatic tally_and_finish;
		if (errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	function automatic logic sel(input int s);
		case (s)
			0: return sck_out;
			1: return transfer_flag;
			default: return transfer_complete_flag;
		endcase
	endfunction
	// a wait that runs dry ends the run as a failure
	task automatic waitf(input int s);
		int i;
		i = 0;
		while (sel(s) !== 1'h1 && i < 3000) begin
			tick(1);
			i++;
		end
		if (sel(s) !== 1'h1) begin
			errors++;
			tally_and_finish();
		end
	endtask
	// bench acts as host towards the client role, msb first, slow enough for the synchroniser
	task automatic cbyte(input logic [7:0] m, input int nb);
		for (int i = 7; i > 7 - nb; i--) begin
			tb_mosi = m[i];
			tb_sck = 1'h1;
			tick(4);
			got_m[i] = miso_in;
			tb_sck = 1'h0;
			tick(4);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		data_wdata = d;
		data_wr = 1'h1;
		tick(1);
		data_wr = 1'h0;
	endtask
	task automatic clr;
		{flag_clear_transfer, flag_clear_collision, flag_clear_complete} = 3'h7;
		tick(1);
		{flag_clear_transfer, flag_clear_collision, flag_clear_complete} = 3'h0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic [7:0] r);
		int n;
		n = 0;
		reply = r;
		exp_q.push_back(r);
		wr(d);
		waitf(0);
		while (sck_out === 1'h1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("sck high", clock_doubler ? half2[clock_prescaler] : half[clock_prescaler], n[7:0]);
		waitf(1);
		chk("client rx", d, got);
		chk1("irq", global_irq_enable, irq);
		tick(4);
		clr();
	endtask
	// ----------------------------------------
	// scoreboard and watchdog
	// ----------------------------------------
	initial forever begin
		@(posedge transfer_flag);
		tick(2);
		if (exp_q.size() > 0) chk("rx data", exp_q.pop_front(), data_rdata);
	end
	// longest prescaler run is some 1100 cycles a byte; 60000 leaves room
	initial begin
		#480000;
		errors++;
		tally_and_finish();
	end
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		tick(10);
		resetn = 1'h1;
		chk1("empty at reset", 1'h1, data_empty_flag);
		chk1("role at reset", 1'h0, host_mode);
		{ss_dir_out, sck_dir_out, mosi_dir_out, transfer_irq_enable} = 4'hF;
		tick(1);
		enable = 1'h1;
		tick(1);
		host_set = 1'h1;
		tick(2);
		for (int k = 0; k < 16; k++) begin
			{clock_doubler, bit_order, clock_prescaler} = k[3:0];
			global_irq_enable = k[0];
			seed = lfsr(seed);
			xfer(seed[7:0], seed[15:8]);
		end
		{clock_doubler, clock_prescaler} = 3'h1;
		wr(8'hA5);
		tick(6);
		wr(8'h5A);
		waitf(1);
		tick(300);
		chk1("collision", 1'h1, write_collision_flag);
		clr();
		buffer_enable = 1'h1;
		wait_for_receive = seed[16];
		{transfer_irq_enable, transfer_complete_enable, global_irq_enable} = 3'h3;
		reply = 8'h3C;
		tick(1);
		wr(8'h11);
		tick(1);
		wr(8'h22);
		chk1("empty after write", 1'h0, data_empty_flag);
		waitf(0);
		reply = 8'hC3;
		waitf(2);
		chk("second byte", 8'h22, got);
		chk1("complete irq", 1'h1, irq);
		chk("queue head", 8'h3C, data_rdata);
		data_rd = 1'h1;
		tick(1);
		data_rd = 1'h0;
		tick(1);
		chk1("queue valid", 1'h1, rx_valid);
		chk("queue next", 8'hC3, data_rdata);
		chk1("empty after move", 1'h1, data_empty_flag);
		clr();
		{buffer_enable, select_disable, ss_dir_out, tb_ss} = 4'h4;
		tick(10);
		chk1("select ignored", 1'h1, host_mode);
		select_disable = 1'h0;
		tick(6);
		chk1("host dropped", 1'h0, host_mode);
		chk1("drop flag", 1'h1, transfer_flag);
		miso_dir_out = 1'h1;
		tick(4);
		chk1("miso driven", 1'h1, miso_oe);
		chk1("sck input", 1'h0, sck_oe);
		chk1("mosi input", 1'h0, mosi_oe);
		chk1("ss input", 1'h0, ss_oe);
		bit_order = 1'h0;
		clr();
		wr(8'h96);
		exp_q.push_back(8'h3A);
		cbyte(8'h3A, 8);
		chk("client miso", 8'h96, got_m);
		chk1("client flag", 1'h1, transfer_flag);
		clr();
		cbyte(8'hFF, 3);
		tb_ss = 1'h1;
		tick(4);
		tb_ss = 1'h0;
		tick(4);
		exp_q.push_back(8'h5C);
		cbyte(8'h5C, 8);
		tb_ss = 1'h1;
		tick(4);
		chk1("miso released", 1'h0, miso_oe);
		chk("notes left", 8'h00, 8'(exp_q.size()));
		tally_and_finish();
	end
endmodule // test_shcc_core
`default_nettype wire
